// >>> core/rfi_axil_slave.sv
`include "rfi_defs.svh"

module rfi_axil_slave #(
    parameter int AW = 8
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          ce,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    output logic               wr_en,
    output logic [AW-1:0]      wr_addr,
    output logic [31:0]        wr_data,
    output logic [3:0]         wr_strb,
    input  wire logic          wr_err,
    output logic [AW-1:0]      rd_addr,
    input  wire logic [31:0]   rd_data,
    input  wire logic          rd_err
);

    initial begin
        if (AW < 5) $error("address too narrow for the register map");
    end

    rfi_pkg::rfi_bus_e wstate;
    rfi_pkg::rfi_bus_e next_wstate;
    logic [1:0]        next_bresp;
    logic              rvalid_q;
    logic              next_rvalid;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;

    // both channels taken in one edge keeps the decode single-cycle
    assign s_axi_awready = ce && wstate == rfi_pkg::RFI_BUS_IDLE && s_axi_awvalid && s_axi_wvalid;
    assign s_axi_wready  = s_axi_awready;
    assign wr_en         = s_axi_awready;
    assign wr_addr       = s_axi_awaddr;
    assign wr_data       = s_axi_wdata;
    assign wr_strb       = s_axi_wstrb;
    assign s_axi_bvalid  = wstate == rfi_pkg::RFI_BUS_RESP;
    assign s_axi_arready = ce && !rvalid_q;
    assign rd_addr       = s_axi_araddr;
    assign s_axi_rvalid  = rvalid_q;

    always_comb begin
        next_wstate = wstate;
        next_bresp  = s_axi_bresp;
        next_rvalid = rvalid_q;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        case (wstate)
            rfi_pkg::RFI_BUS_IDLE: begin
                if (wr_en) begin
                    next_wstate = rfi_pkg::RFI_BUS_RESP;
                    next_bresp  = wr_err ? `RFI_RESP_SLVERR : `RFI_RESP_OKAY;
                end
            end
            rfi_pkg::RFI_BUS_RESP: begin
                if (s_axi_bready) begin
                    next_wstate = rfi_pkg::RFI_BUS_IDLE;
                end
            end
            default: next_wstate = rfi_pkg::RFI_BUS_IDLE;
        endcase
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata  = rd_err ? 32'h0000_0000 : rd_data;
            next_rresp  = rd_err ? `RFI_RESP_SLVERR : `RFI_RESP_OKAY;
        end else if (rvalid_q && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstate      <= rfi_pkg::RFI_BUS_IDLE;
            s_axi_bresp <= `RFI_RESP_OKAY;
            rvalid_q    <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RFI_RESP_OKAY;
        end else if (ce) begin
            wstate      <= next_wstate;
            s_axi_bresp <= next_bresp;
            rvalid_q    <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

endmodule

// >>> core/rfi_swing_buf.sv
`include "rfi_defs.svh"

module rfi_swing_buf #(
    parameter int W = 32
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic         load,
    input  wire logic [W-1:0] load_data,
    input  wire logic         swap,
    input  wire logic         overrun,
    output logic [W-1:0]      host_data,
    output logic [W-1:0]      rcv_data,
    output logic              host_sel
);

    initial begin
        if (W < 1) $error("buffer width must be positive");
    end

    logic [W-1:0] mem [2];
    logic [W-1:0] next_mem [2];
    logic         next_host_sel;
    logic         wr_idx;

    // an overrun lets the receiver land in the host's half: that is the corruption
    assign wr_idx    = overrun ? host_sel : !host_sel;
    assign host_data = mem[host_sel];
    assign rcv_data  = mem[!host_sel];

    always_comb begin
        next_mem      = mem;
        next_host_sel = host_sel;
        if (load) begin
            next_mem[wr_idx] = load_data;
        end
        if (swap) begin
            next_host_sel = !host_sel;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem[0]   <= W'(`RFI_FRAME_INFO_RST);
            mem[1]   <= W'(`RFI_FRAME_INFO_RST);
            host_sel <= 1'b0;
        end else if (ce) begin
            mem      <= next_mem;
            host_sel <= next_host_sel;
        end
    end

endmodule

// >>> core/rfi_top.sv
// The implementer's own choice: register access over AXI4-Lite.
`include "rfi_defs.svh"

// Function
// RQ1 - the frame information is a read-only 32-bit register at 0x10.
// RQ2 - only a header whose error check found no uncorrectable error loads it.
// RQ3 - it belongs to the double-buffered set and switches with the other receive results.
// RQ4 - a receiver overrun corrupts it and the host must then distrust it.
// RQ5 - bits 6 to 0 take the header length when the header-detected flag is set.
// RQ6 - in standard operation the seven-bit length covers frames up to 127 bytes.
// RQ7 - in long-frame mode bits 9 to 7 extend the length to 10 bits, up to 1023 octets.
// RQ8 - the preamble indicator is reported together with the symbol repetition field.
// RQ9 - fields sit at 31:20, 19:18, 17:16, 15, 14:13, 12:11, reserved 10, all reset to zero.
// RQ10 - bit 10 reads zero and host writes change no field.
module rfi_top #(
    parameter int AW = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    input  wire logic [AW-1:0]     s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AW-1:0]     s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  rfi_pkg::rfi_hdr_evt_s  header_detected_flag,
    input  wire logic              rx_buffer_swap,
    input  wire logic              rx_overrun,
    output logic                   long_frame_mode
);

    initial begin
        if (AW < 5) $error("address too narrow for the register map");
    end

    function automatic logic [31:0] pack_info(input rfi_pkg::rfi_hdr_s h, input logic long_mode);
        logic [31:0] w;
        w = `RFI_FRAME_INFO_RST;
        w[`RFI_LEN_MSB:`RFI_LEN_LSB]   = h.len;
        w[`RFI_EXT_MSB:`RFI_EXT_LSB]   = long_mode ? h.ext : 3'h0;
        w[`RFI_RSVD_BIT]               = 1'b0;
        w[`RFI_NSPL_MSB:`RFI_NSPL_LSB] = h.nspl;
        w[`RFI_RATE_MSB:`RFI_RATE_LSB] = h.rate;
        w[`RFI_RNG_BIT]                = h.ranging_bit;
        w[`RFI_PRF_MSB:`RFI_PRF_LSB]   = h.prf;
        w[`RFI_PSR_MSB:`RFI_PSR_LSB]   = h.psr;
        w[`RFI_PACC_MSB:`RFI_PACC_LSB] = h.pacc;
        return w;
    endfunction

    function automatic logic word_hit(input logic [AW-1:0] a, input logic [7:0] off);
        logic [AW-1:0] o;
        o = AW'(off);
        return a[AW-1:2] == o[AW-1:2];
    endfunction

    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [31:0]   wr_data;
    logic [3:0]    wr_strb;
    logic          wr_err;
    logic [AW-1:0] rd_addr;
    logic [31:0]   rd_data;
    logic          rd_err;
    logic          good_hdr;
    logic [31:0]   cap_word;
    logic [31:0]   rx_frame_info;
    logic [31:0]   rcv_word;
    logic          host_sel;
    logic          overrun_seen;
    logic          next_overrun_seen;
    logic          next_long_frame_mode;
    logic          ctrl_hit;
    logic          stat_hit;

    rfi_axil_slave #(
        .AW (AW)
    ) u_bus (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .ce            (ce),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_err        (wr_err),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_err        (rd_err)
    );

    // a header with an uncorrectable error never reaches the register
    assign good_hdr = header_detected_flag.valid && !header_detected_flag.secded_err; // RQ2
    assign cap_word = pack_info(header_detected_flag.fields, long_frame_mode); // RQ5 RQ7 RQ8 RQ9

    rfi_swing_buf #(
        .W (32)
    ) u_swing (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .load      (good_hdr),
        .load_data (cap_word),
        .swap      (rx_buffer_swap), // RQ3
        .overrun   (rx_overrun), // RQ4
        .host_data (rx_frame_info),
        .rcv_data  (rcv_word),
        .host_sel  (host_sel)
    );

    assign ctrl_hit = word_hit(wr_addr, `RFI_OFF_CTRL);
    assign stat_hit = word_hit(wr_addr, `RFI_OFF_STATUS);
    // writes to the frame information word are accepted and dropped
    assign wr_err   = !(word_hit(wr_addr, `RFI_OFF_FRAME_INFO) || ctrl_hit || stat_hit); // RQ10

    always_comb begin
        rd_err  = 1'b0;
        rd_data = 32'h0000_0000;
        if (word_hit(rd_addr, `RFI_OFF_FRAME_INFO)) begin
            rd_data = rx_frame_info; // RQ1
        end else if (word_hit(rd_addr, `RFI_OFF_CTRL)) begin
            rd_data[`RFI_CTRL_LONG_BIT] = long_frame_mode;
        end else if (word_hit(rd_addr, `RFI_OFF_STATUS)) begin
            rd_data[`RFI_STAT_SEL_BIT] = host_sel;
            rd_data[`RFI_STAT_OVR_BIT] = overrun_seen;
        end else begin
            rd_err = 1'b1;
        end
    end

    always_comb begin
        next_long_frame_mode = long_frame_mode;
        next_overrun_seen    = overrun_seen;
        if (wr_en && ctrl_hit && wr_strb[0]) begin
            next_long_frame_mode = wr_data[`RFI_CTRL_LONG_BIT]; // RQ6 RQ7
        end
        if (wr_en && stat_hit && wr_strb[0] && wr_data[`RFI_STAT_OVR_BIT]) begin
            next_overrun_seen = 1'b0;
        end
        // set after clear: a fresh overrun is never lost
        if (rx_overrun) begin
            next_overrun_seen = 1'b1; // RQ4
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            long_frame_mode <= 1'b0;
            overrun_seen    <= 1'b0;
        end else if (ce) begin
            long_frame_mode <= next_long_frame_mode;
            overrun_seen    <= next_overrun_seen;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_good_load;
        ce && good_hdr && !rx_overrun && !rx_buffer_swap;
    endsequence

    sequence s_bad_hdr;
        ce && header_detected_flag.valid && header_detected_flag.secded_err;
    endsequence

    a_reserved_reads_zero: assert property ( // RQ10
        rx_frame_info[`RFI_RSVD_BIT] == 1'b0 && rcv_word[`RFI_RSVD_BIT] == 1'b0)
        else $error("reserved bit is not zero");

    a_bad_header_ignored: assert property ( // RQ2
        s_bad_hdr and (!rx_overrun && !rx_buffer_swap) |=> $stable(rcv_word) && $stable(rx_frame_info))
        else $error("errored header changed the register");

    a_length_copied: assert property ( // RQ5
        s_good_load |=> rcv_word[`RFI_LEN_MSB:`RFI_LEN_LSB] == $past(header_detected_flag.fields.len))
        else $error("frame length not copied from header");

    a_std_ext_zero: assert property ( // RQ6
        s_good_load and !long_frame_mode |=> rcv_word[`RFI_EXT_MSB:`RFI_EXT_LSB] == 3'h0)
        else $error("extension set in standard mode");

    a_long_ext_copied: assert property ( // RQ7
        s_good_load and long_frame_mode
        |=> rcv_word[`RFI_EXT_MSB:`RFI_EXT_LSB] == $past(header_detected_flag.fields.ext))
        else $error("extension not copied in long mode");

    a_preamble_pair: assert property ( // RQ8
        s_good_load |=> rcv_word[`RFI_NSPL_MSB:`RFI_NSPL_LSB] == $past(header_detected_flag.fields.nspl)
            && rcv_word[`RFI_PSR_MSB:`RFI_PSR_LSB] == $past(header_detected_flag.fields.psr))
        else $error("preamble pair not reported together");

    a_swap_together: assert property ( // RQ3
        ce && rx_buffer_swap && !good_hdr |=> rx_frame_info == $past(rcv_word) && host_sel != $past(host_sel))
        else $error("swing did not switch the host view");

    a_overrun_corrupts: assert property ( // RQ4
        ce && rx_overrun && good_hdr && !rx_buffer_swap
        |=> rx_frame_info == $past(cap_word) && overrun_seen)
        else $error("overrun did not corrupt host view");

    a_reset_clears: assert property ( // RQ9
        $rose(aresetn) |-> rx_frame_info == `RFI_FRAME_INFO_RST && rcv_word == `RFI_FRAME_INFO_RST)
        else $error("frame information not zero after reset");

    a_write_dropped: assert property ( // RQ10
        wr_en && word_hit(wr_addr, `RFI_OFF_FRAME_INFO) && !good_hdr && !rx_buffer_swap
        |=> $stable(rx_frame_info))
        else $error("host write changed frame information");

    a_read_answers: assert property ( // RQ1
        s_axi_arvalid && s_axi_arready && word_hit(s_axi_araddr, `RFI_OFF_FRAME_INFO)
        |=> s_axi_rvalid && s_axi_rresp == `RFI_RESP_OKAY && s_axi_rdata == $past(rx_frame_info))
        else $error("frame information read answered wrongly");

endmodule

// >>> dv/rfi_rx_model.sv
module rfi_rx_model (
    input  wire logic             aclk,
    output rfi_pkg::rfi_hdr_evt_s hdr,
    output logic                  swap,
    output logic                  ovr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        hdr = '0;
        swap = 1'b0;
        ovr = 1'b0;
    end

    // last=0 keeps the strobe up so the next header follows back to back
    task automatic send(input rfi_pkg::rfi_hdr_s f, input logic err, input logic last);
        hdr <= {1'b1, err, f};
        @(posedge aclk);
        if (last) begin
            // released lines never hold the last value
            hdr <= {1'b0, ~err, ~f};
        end
    endtask

    task automatic swing();
        swap <= 1'b1;
        @(posedge aclk);
        swap <= 1'b0;
    endtask

    task automatic set_ovr(input logic v);
        ovr <= v;
        @(posedge aclk);
    endtask
endmodule

// >>> dv/testbench.sv
`include "rfi_defs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  aclk, aresetn, awv, wv, awr, wr_rdy, bv, arv, arr, rv, lfm, swp, ovr;
    logic [7:0]            awa, ara;
    logic [31:0]           wd, rdat, v, host_e, rcv_e;
    logic [1:0]            br, rr, r;
    logic [3:0]            ws;
    logic                  brdy;
    logic                  long_e, sel_e, err;
    int                    fail_count, checked, seed;
    rfi_pkg::rfi_hdr_evt_s hdr;
    rfi_pkg::rfi_hdr_s     f;

    rfi_top rfi_top_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
        .header_detected_flag(hdr), .rx_buffer_swap(swp), .rx_overrun(ovr),
        .long_frame_mode(lfm)
    );

    rfi_rx_model rfi_rx_model_inst (.aclk(aclk), .hdr(hdr), .swap(swp), .ovr(ovr));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    function automatic logic [31:0] pack(input rfi_pkg::rfi_hdr_s h, input logic lm);
        return {h.pacc, h.psr, h.prf, h.ranging_bit, h.rate, h.nspl, 1'b0, lm ? h.ext : 3'h0, h.len};
    endfunction

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic stop_test();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // bready and rready stay high, so the answer is taken where it is seen
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        int n;
        n = 0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        // sample ready mid-cycle: at the taking edge it is already falling
        do @(negedge aclk); while (!(awr && wr_rdy) && ++n < 100);
        @(posedge aclk);
        awv <= 1'b0;
        wv <= 1'b0;
        do @(negedge aclk); while (!bv && ++n < 100);
        rs = br;
        @(posedge aclk);
        if (n >= 100) fail_count++;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        int n;
        n = 0;
        ara <= a;
        arv <= 1'b1;
        do @(negedge aclk); while (!arr && ++n < 100);
        @(posedge aclk);
        arv <= 1'b0;
        do @(negedge aclk); while (!rv && ++n < 100);
        d = rdat;
        rs = rr;
        @(posedge aclk);
        if (n >= 100) fail_count++;
    endtask

    initial begin
        #100000;
        fail_count++;
        stop_test();
    end

    initial begin
        seed = 44;
        aresetn = 1'b0;
        {awv, wv, arv} = 3'h0;
        ws = 4'hF;
        brdy = 1'b1;
        {awa, ara, wd} = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(8'h10, v, r);
        chk(v, 32'h0000_0000);
        chk({30'h0, r}, {30'h0, `RFI_RESP_OKAY});
        axw(8'h10, 32'hFFFF_FFFF, r);
        chk({30'h0, r}, {30'h0, `RFI_RESP_OKAY});
        axr(8'h10, v, r);
        chk(v, 32'h0000_0000);
        axr(8'h40, v, r);
        chk({30'h0, r}, {30'h0, `RFI_RESP_SLVERR});
        host_e = '0;
        rcv_e = '0;
        sel_e = 1'b0;
        for (int i = 0; i < 60; i++) begin
            f = rfi_pkg::rfi_hdr_s'($random(seed));
            // corner: full 127 length at i=0 in whichever mode is drawn, then 1023 long at i=1
            if (i < 2) f = '1;
            long_e = (i == 1) || ($random(seed) % 2 != 0);
            err = (i % 4 == 3);
            axw(8'h14, {31'h0, long_e}, r);
            chk({31'h0, lfm}, {31'h0, long_e});
            if (i % 5 == 2) begin
                rfi_rx_model_inst.send(~f, 1'b0, 1'b0);
                rcv_e = pack(~f, long_e);
            end
            rfi_rx_model_inst.send(f, err, 1'b1);
            if (!err) rcv_e = pack(f, long_e);
            axr(8'h10, v, r);
            chk(v, host_e);
            rfi_rx_model_inst.swing();
            {host_e, rcv_e} = {rcv_e, host_e};
            sel_e = ~sel_e;
            axr(8'h10, v, r);
            chk(v, host_e);
            axr(8'h18, v, r);
            chk({31'h0, v[0]}, {31'h0, sel_e});
        end
        // overrun lets the receiver load land in the host half
        rfi_rx_model_inst.set_ovr(1'b1);
        f = rfi_pkg::rfi_hdr_s'($random(seed));
        rfi_rx_model_inst.send(f, 1'b0, 1'b1);
        rfi_rx_model_inst.set_ovr(1'b0);
        axr(8'h10, v, r);
        chk(v, pack(f, long_e));
        axr(8'h18, v, r);
        chk({31'h0, v[1]}, 32'h0000_0001);
        axw(8'h18, 32'h0000_0002, r);
        axr(8'h18, v, r);
        chk({31'h0, v[1]}, 32'h0000_0000);
        stop_test();
    end
endmodule

// >>> pkg/rfi_defs.svh
`ifndef RFI_DEFS_SVH
`define RFI_DEFS_SVH

`define RFI_OFF_FRAME_INFO 8'h10
`define RFI_OFF_CTRL       8'h14
`define RFI_OFF_STATUS     8'h18

`define RFI_LEN_LSB        0
`define RFI_LEN_MSB        6
`define RFI_EXT_LSB        7
`define RFI_EXT_MSB        9
`define RFI_RSVD_BIT       10
`define RFI_NSPL_LSB       11
`define RFI_NSPL_MSB       12
`define RFI_RATE_LSB       13
`define RFI_RATE_MSB       14
`define RFI_RNG_BIT        15
`define RFI_PRF_LSB        16
`define RFI_PRF_MSB        17
`define RFI_PSR_LSB        18
`define RFI_PSR_MSB        19
`define RFI_PACC_LSB       20
`define RFI_PACC_MSB       31

`define RFI_CTRL_LONG_BIT  0
`define RFI_STAT_SEL_BIT   0
`define RFI_STAT_OVR_BIT   1

`define RFI_FRAME_INFO_RST 32'h0000_0000
`define RFI_CTRL_RST       32'h0000_0000

`define RFI_RESP_OKAY      2'h0
`define RFI_RESP_SLVERR    2'h2

`endif

// >>> pkg/rfi_pkg.sv
package rfi_pkg;

    typedef struct packed {
        logic [11:0] pacc;
        logic [1:0]  psr;
        logic [1:0]  prf;
        logic        ranging_bit;
        logic [1:0]  rate;
        logic [1:0]  nspl;
        logic [2:0]  ext;
        logic [6:0]  len;
    } rfi_hdr_s;

    typedef struct packed {
        logic        valid;
        logic        secded_err;
        rfi_hdr_s    fields;
    } rfi_hdr_evt_s;

    typedef enum logic [0:0] {
        RFI_BUS_IDLE,
        RFI_BUS_RESP
    } rfi_bus_e;

endpackage
